// ===== reg_bank.sv
/*
 * Small byte-wide register bank for the chip registers that the
 * decoder does not keep in flops. Read data come from a register,
 * one cycle after the address.
 */
`timescale 1ns/10ps
`default_nettype none
module reg_bank #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input wire logic clk_in,
    input wire logic ce_in,
    input wire logic we_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [DW-1:0] wdata_in,
    output logic [DW-1:0] rdata_out
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    initial begin
        if (AW < 1 || AW > 12 || DW < 1) begin
            $error("reg_bank: unsupported size");
        end
    end

    always_ff @(posedge clk_in) begin
        if (ce_in && we_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            rdata_out <= mem[addr_in];
        end
    end
endmodule
`default_nettype wire

// ===== rw_decoder.sv
/*
 * Script I/O and register read/write instruction decoder with its
 * AXI4-Lite register slave. Assumes one clock, instruction words
 * written by software, and a SCSI core that reports selection outcome
 * and a memory port that serves table fetches on the same clock.
 */
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module rw_decoder
    import rw_decoder_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic [7:0] s_awaddr_in,
    input wire logic s_awvalid_in,
    output logic s_awready_out,
    input wire logic [31:0] s_wdata_in,
    input wire logic [3:0] s_wstrb_in,
    input wire logic s_wvalid_in,
    output logic s_wready_out,
    output logic [1:0] s_bresp_out,
    output logic s_bvalid_out,
    input wire logic s_bready_in,
    input wire logic [7:0] s_araddr_in,
    input wire logic s_arvalid_in,
    output logic s_arready_out,
    output logic [31:0] s_rdata_out,
    output logic [1:0] s_rresp_out,
    output logic s_rvalid_out,
    input wire logic s_rready_in,
    output logic tbl_req_out,
    output logic [31:0] tbl_addr_out,
    input wire logic tbl_ack_in,
    input wire rw_decoder_pkg::table_entry_s tbl_data_in,
    output logic sel_start_out,
    output logic [3:0] sel_id_out,
    output logic sel_atn_out,
    input wire logic sel_ok_in,
    input wire logic sel_fail_in,
    output logic jump_out,
    output logic illegal_out,
    output rw_decoder_pkg::scsi_ctl_s scsi_out
);
    import rw_decoder_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_flop_reg(input logic [6:0] a);
        return a == R_ROLE || a == R_TIMING || a == R_FIRST || a == R_OCL || a == R_LOOP;
    endfunction

    function automatic logic [31:0] sext24(input logic [23:0] v);
        return {{8{v[23]}}, v};
    endfunction

    // Result in the low byte, carry out in bit 8.
    function automatic logic [8:0] alu(input alu_op_e op, input logic [7:0] a, input logic [7:0] b, input logic c);
        logic [8:0] r;
        r = {c, a};
        case (op)
            ALU_LOAD: r = {c, b};
            ALU_SHL: r = {a[7], a[6:0], c};
            ALU_OR: r = {c, a | b};
            ALU_XOR: r = {c, a ^ b};
            ALU_AND: r = {c, a & b};
            ALU_SHR: r = {a[0], c, a[7:1]};
            ALU_ADD: r = {1'b0, a} + {1'b0, b};
            ALU_ADDC: r = {1'b0, a} + {1'b0, b} + {8'h00, c};
            default: r = {c, a};
        endcase
        return r;
    endfunction

    state_e state_q;
    logic [31:0] word0_q, word1_q, dsb_q, ptr_q, jump_q;
    logic start_q, illegal_q, jumped_q, carry_q;
    logic [7:0] role_q, timing_q, first_q, ocl_q, loop_q, id_q, sync_q;
    logic [7:0] opnd_q, bank_rdata;
    logic bank_we;
    logic [7:0] bank_wdata;
    logic aw_have_q, w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire, ctrl_start, illegal_set;
    logic [8:0] alu_res;

    wire logic [2:0] opcode = word0_q[29:27];
    wire logic is_io = opcode <= OP_CLEAR;
    wire logic [6:0] raddr = word0_q[22:16];
    wire logic [7:0] imm = word0_q[15:8];
    wire logic tbl_mode = word0_q[F_TABLE];
    wire logic rel_mode = word0_q[F_REL];
    wire logic is_busy = state_q != S_IDLE;

    reg_bank #(.AW(7), .DW(8)) u_bank (
        .clk_in(clk_in),
        .ce_in(ce_in),
        .we_in(bank_we),
        .addr_in(raddr),
        .wdata_in(bank_wdata),
        .rdata_out(bank_rdata)
    );

    // Bus slave: address and data are taken independently.
    assign s_awready_out = !aw_have_q && !s_bvalid_out;
    assign s_wready_out = !w_have_q && !s_bvalid_out;
    assign s_arready_out = !s_rvalid_out;
    assign wr_fire = aw_have_q && w_have_q && !s_bvalid_out;
    assign ctrl_start = wr_fire && aw_addr_q == A_CTRL && w_strb_q[0] && w_data_q[0];

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_bvalid_out <= 1'b0;
            s_bresp_out <= 2'h0;
        end else if (ce_in) begin
            if (s_awvalid_in && s_awready_out) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_awaddr_in;
            end
            if (s_wvalid_in && s_wready_out) begin
                w_have_q <= 1'b1;
                w_data_q <= s_wdata_in;
                w_strb_q <= s_wstrb_in;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_bvalid_out <= 1'b1;
                s_bresp_out <= aw_addr_q > A_TABLE || aw_addr_q[1:0] != 2'h0 ? 2'h3 : 2'h0;
            end else if (s_bready_in) begin
                s_bvalid_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s_rvalid_out <= 1'b0;
            s_rdata_out <= 32'h0000_0000;
            s_rresp_out <= 2'h0;
        end else if (ce_in) begin
            if (s_arvalid_in && s_arready_out) begin
                s_rvalid_out <= 1'b1;
                s_rresp_out <= 2'h0;
                case (s_araddr_in)
                    A_WORD0: s_rdata_out <= word0_q;
                    A_WORD1: s_rdata_out <= word1_q;
                    A_CTRL: s_rdata_out <= 32'h0000_0000;
                    A_STATUS: s_rdata_out <= {16'h0000, first_q, 3'h0, role_q[0], carry_q, jumped_q, illegal_q, is_busy};
                    A_DSB: s_rdata_out <= dsb_q;
                    A_PTR: s_rdata_out <= ptr_q;
                    A_JUMP: s_rdata_out <= jump_q;
                    A_TABLE: s_rdata_out <= {timing_q, id_q, sync_q, 8'h00};
                    default: begin
                        s_rdata_out <= 32'h0000_0000;
                        s_rresp_out <= 2'h3;
                    end
                endcase
            end else if (s_rready_in) begin
                s_rvalid_out <= 1'b0;
            end
        end
    end

    // Software-visible words. A busy decoder keeps its instruction stable.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            word0_q <= 32'h0000_0000;
            word1_q <= 32'h0000_0000;
            dsb_q <= 32'h0000_0000;
        end else if (ce_in && wr_fire) begin
            if (aw_addr_q == A_WORD0 && !is_busy) word0_q <= merge(word0_q, w_data_q, w_strb_q);
            if (aw_addr_q == A_WORD1 && !is_busy) word1_q <= merge(word1_q, w_data_q, w_strb_q);
            if (aw_addr_q == A_DSB) dsb_q <= merge(dsb_q, w_data_q, w_strb_q);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ptr_q <= 32'h0000_0000;
        end else if (ce_in && wr_fire && aw_addr_q == A_PTR) begin
            ptr_q <= merge(ptr_q, w_data_q, w_strb_q);
        end else if (ce_in && state_q == S_SELWAIT && sel_fail_in) begin
            ptr_q <= jump_q;
        end
    end

    assign illegal_set = state_q == S_DECODE && is_io && word0_q[F_SELATN] && opcode != OP_SELECT;

    // Sticky flags: a hardware set in the same cycle beats a software clear.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            illegal_q <= 1'b0;
            jumped_q <= 1'b0;
        end else if (ce_in) begin
            if (wr_fire && aw_addr_q == A_STATUS && w_strb_q[0]) begin
                if (w_data_q[ST_ILLEGAL]) illegal_q <= 1'b0;
                if (w_data_q[ST_JUMPED]) jumped_q <= 1'b0;
            end
            if (illegal_set) illegal_q <= 1'b1;
            if (state_q == S_SELWAIT && sel_fail_in) jumped_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            start_q <= 1'b0;
        end else if (ce_in) begin
            start_q <= ctrl_start && !is_busy;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state_q <= S_IDLE;
        end else if (ce_in) begin
            case (state_q)
                S_IDLE: if (start_q) state_q <= S_DECODE;
                S_DECODE: begin
                    if (!is_io) state_q <= S_READ;
                    else if (illegal_set) state_q <= S_IDLE;
                    else if (opcode == OP_SELECT && tbl_mode) state_q <= S_TFETCH;
                    else if (opcode == OP_SELECT || opcode == OP_WAITRES) state_q <= S_SELWAIT;
                    else state_q <= S_IDLE;
                end
                S_READ: state_q <= S_WRITE;
                S_WRITE: state_q <= S_IDLE;
                S_TFETCH: if (tbl_ack_in) state_q <= S_SELWAIT;
                S_SELWAIT: if (sel_ok_in || sel_fail_in) state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Jump target on a failed selection, absolute or relative to the pointer.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            jump_q <= 32'h0000_0000;
        end else if (ce_in && state_q == S_DECODE && is_io) begin
            jump_q <= rel_mode ? ptr_q + sext24(word1_q[23:0]) : word1_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            tbl_req_out <= 1'b0;
            tbl_addr_out <= 32'h0000_0000;
        end else if (ce_in) begin
            if (state_q == S_DECODE && is_io && opcode == OP_SELECT && tbl_mode && !illegal_set) begin
                tbl_req_out <= 1'b1;
                tbl_addr_out <= dsb_q + sext24(word0_q[23:0]);
            end else if (tbl_ack_in) begin
                tbl_req_out <= 1'b0;
            end
        end
    end

    // Table data arrive as one word; the device ID only uses its low nibble.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            id_q <= 8'h00;
            sync_q <= 8'h00;
        end else if (ce_in) begin
            if (state_q == S_TFETCH && tbl_ack_in) begin
                id_q <= tbl_data_in.id;
                sync_q <= tbl_data_in.sync;
            end else if (state_q == S_DECODE && is_io && !tbl_mode) begin
                id_q <= {4'h0, word0_q[19:16]};
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            sel_start_out <= 1'b0;
            sel_atn_out <= 1'b0;
            sel_id_out <= 4'h0;
            jump_out <= 1'b0;
        end else if (ce_in) begin
            sel_start_out <= 1'b0;
            jump_out <= state_q == S_SELWAIT && sel_fail_in && !sel_ok_in;
            if ((state_q == S_DECODE && is_io && !illegal_set && !tbl_mode
                 && (opcode == OP_SELECT || opcode == OP_WAITRES))
                || (state_q == S_TFETCH && tbl_ack_in)) begin
                sel_start_out <= 1'b1;
                sel_id_out <= state_q == S_TFETCH ? tbl_data_in.id[3:0] : word0_q[19:16];
                sel_atn_out <= opcode == OP_SELECT && word0_q[F_SELATN];
            end else if (state_q == S_SELWAIT && (sel_ok_in || sel_fail_in)) begin
                sel_atn_out <= 1'b0;
            end
        end
    end

    assign alu_res = alu(alu_op_e'(word0_q[26:24]), opnd_q,
                         word0_q[F_USEFB] ? first_q : imm, carry_q);

    // First operand: the addressed register, or the first byte for op 101.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            opnd_q <= 8'h00;
        end else if (ce_in && state_q == S_READ) begin
            if (opcode == OP_FROMFB) opnd_q <= first_q;
            else if (!is_flop_reg(raddr)) opnd_q <= bank_rdata;
            else if (raddr == R_ROLE) opnd_q <= role_q;
            else if (raddr == R_TIMING) opnd_q <= timing_q;
            else if (raddr == R_FIRST) opnd_q <= first_q;
            else if (raddr == R_OCL) opnd_q <= ocl_q;
            else opnd_q <= loop_q;
        end
    end

    wire logic wr_reg = state_q == S_WRITE && opcode != OP_TOFB;
    assign bank_we = wr_reg && !is_flop_reg(raddr);
    assign bank_wdata = alu_res[7:0];

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            carry_q <= 1'b0;
        end else if (ce_in) begin
            if (state_q == S_WRITE) carry_q <= alu_res[8];
            else if (state_q == S_DECODE && word0_q[F_CARRY] && opcode == OP_SET) carry_q <= 1'b1;
            else if (state_q == S_DECODE && word0_q[F_CARRY] && opcode == OP_CLEAR) carry_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            first_q <= 8'h00;
            timing_q <= 8'h00;
            loop_q <= 8'h00;
        end else if (ce_in) begin
            if (state_q == S_WRITE && opcode == OP_TOFB) first_q <= alu_res[7:0];
            if (wr_reg && raddr == R_FIRST) first_q <= alu_res[7:0];
            if (wr_reg && raddr == R_LOOP) loop_q <= alu_res[7:0];
            if (wr_reg && raddr == R_TIMING) timing_q <= alu_res[7:0];
            else if (state_q == S_TFETCH && tbl_ack_in) timing_q <= tbl_data_in.timing;
        end
    end

    wire logic set_clr = state_q == S_DECODE && (opcode == OP_SET || opcode == OP_CLEAR);
    wire logic set_val = opcode == OP_SET;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            role_q <= 8'h00;
            ocl_q <= 8'h00;
        end else if (ce_in) begin
            if (wr_reg && raddr == R_ROLE) role_q <= alu_res[7:0];
            else if (set_clr && word0_q[F_TARGET]) role_q[0] <= set_val;
            if (wr_reg && raddr == R_OCL) ocl_q <= alu_res[7:0];
            else if (set_clr) begin
                if (word0_q[F_ACK]) ocl_q[OCL_ACK] <= set_val;
                if (word0_q[F_ATN]) ocl_q[OCL_ATN] <= set_val;
            end
        end
    end

    // Initiator ACK and ATN latches stay off the bus in target role unless looped back; selection attention (sel_atn_out) drives ATN in either role.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            scsi_out <= '0;
            illegal_out <= 1'b0;
        end else if (ce_in) begin
            scsi_out.ack_oe <= ocl_q[OCL_ACK] && (!role_q[0] || loop_q[LOOP_EN]);
            scsi_out.atn_oe <= (ocl_q[OCL_ATN] && (!role_q[0] || loop_q[LOOP_EN])) || sel_atn_out;
            scsi_out.target_role <= role_q[0];
            illegal_out <= illegal_set;
        end
    end
endmodule
`default_nettype wire

// ===== rw_decoder_chk.sv
/*
 * Port assertions for the script decoder.
 * Assumes one clock and the reset of the decoder itself.
 */
`timescale 1ns/10ps
`default_nettype none
module rw_decoder_chk (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic tbl_req_out,
    input wire logic [31:0] tbl_addr_out,
    input wire logic tbl_ack_in,
    input wire logic sel_start_out,
    input wire logic [3:0] sel_id_out,
    input wire logic sel_atn_out,
    input wire logic sel_ok_in,
    input wire logic sel_fail_in,
    input wire logic jump_out,
    input wire logic illegal_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    start_after_ack_a: assert property (tbl_req_out && tbl_ack_in |=> sel_start_out)
        else $error("no select after fetch");
    req_hold_a: assert property (tbl_req_out && !tbl_ack_in |=> tbl_req_out && $stable(tbl_addr_out))
        else $error("request dropped");
    fetch_first_a: assert property (tbl_req_out |-> !sel_start_out)
        else $error("select before data");
    jump_on_fail_a: assert property (sel_fail_in |=> jump_out)
        else $error("no jump after fail");
    jump_pulse_a: assert property (jump_out |=> !jump_out)
        else $error("jump pulse too long");
    atn_hold_a: assert property (sel_atn_out && !sel_ok_in && !sel_fail_in |=> sel_atn_out)
        else $error("attention dropped early");
    atn_drop_a: assert property (sel_ok_in || sel_fail_in |=> !sel_atn_out)
        else $error("attention held");
    illegal_pulse_a: assert property (illegal_out |=> !illegal_out)
        else $error("illegal pulse too long");
    id_stable_a: assert property (sel_atn_out && $past(sel_atn_out) |-> $stable(sel_id_out))
        else $error("id changed");
endmodule
bind rw_decoder rw_decoder_chk u_chk (.clk_in, .nrst_in, .tbl_req_out, .tbl_addr_out, .tbl_ack_in,
    .sel_start_out, .sel_id_out, .sel_atn_out, .sel_ok_in, .sel_fail_in, .jump_out, .illegal_out);
`default_nettype wire

// ===== rw_decoder_pkg.sv
/*
 * Constants, types and bus map for the script I/O and register
 * read/write decoder. Assumes a single core clock domain.
 */
// Contract
// - Table indirect: absolute jump, table ID and sync.
// - Relative: instruction ID, signed jump offset.
// - Table fetch address is base plus word0 bits 23 to 0.
// - Bit 24 on Select asserts attention during selection.
// - Bit 24 on other I/O ops flags illegal.
// - Destination ID comes from bits 19 to 16.
// - Bit 10 sets or clears the carry flag.
// - Bit 9 sets or clears role bit 0.
// - Bits 6, 3 set or clear ACK, ATN latches.
// - ACK, ATN latches driven only as initiator or looped back; Select attention drives ATN in either role.
// - Failed selection jumps to word1.
// - Relative modes add signed offset to pointer.
// - Read/write combines register with first byte or immediate.
// - Op codes 000 to 100 are I/O, others read/write.
// - Bit 23 uses first byte instead of immediate.
// - Bits 22 to 16 address the 8-bit register.
// - Immediate byte is bits 15 to 8.
// - Op 111 writes result back to addressed register.
// - Op 110 writes first byte; op 101 reads it.
// - Bits 26 to 24 select the ALU operator.
// - Shifts rotate through the carry flag.
// - No subtract with first byte; software complements and adds.
// - One table word loads config, ID, offset and period.
package rw_decoder_pkg;
    // Register map, byte addresses.
    localparam logic [7:0] A_WORD0 = 8'h00;
    localparam logic [7:0] A_WORD1 = 8'h04;
    localparam logic [7:0] A_CTRL = 8'h08;
    localparam logic [7:0] A_STATUS = 8'h0c;
    localparam logic [7:0] A_DSB = 8'h10;
    localparam logic [7:0] A_PTR = 8'h14;
    localparam logic [7:0] A_JUMP = 8'h18;
    localparam logic [7:0] A_TABLE = 8'h1c;
    localparam int ST_BUSY = 0;
    localparam int ST_ILLEGAL = 1;
    localparam int ST_JUMPED = 2;
    localparam int ST_CARRY = 3;
    localparam int ST_TARGET = 4;
    // Internal 8-bit register addresses.
    localparam logic [6:0] R_ROLE = 7'h00;
    localparam logic [6:0] R_TIMING = 7'h03;
    localparam logic [6:0] R_FIRST = 7'h08;
    localparam logic [6:0] R_OCL = 7'h0c;
    localparam logic [6:0] R_LOOP = 7'h4e;
    localparam int OCL_ACK = 6;
    localparam int OCL_ATN = 3;
    localparam int LOOP_EN = 4;
    // Instruction fields.
    localparam int F_SELATN = 24;
    localparam int F_TABLE = 25;
    localparam int F_REL = 26;
    localparam int F_USEFB = 23;
    localparam int F_CARRY = 10;
    localparam int F_TARGET = 9;
    localparam int F_ACK = 6;
    localparam int F_ATN = 3;
    localparam logic [2:0] OP_SELECT = 3'h0;
    localparam logic [2:0] OP_WAITRES = 3'h2;
    localparam logic [2:0] OP_SET = 3'h3;
    localparam logic [2:0] OP_CLEAR = 3'h4;
    localparam logic [2:0] OP_FROMFB = 3'h5;
    localparam logic [2:0] OP_TOFB = 3'h6;
    localparam logic [2:0] OP_RMW = 3'h7;
    typedef enum logic [2:0] {
        ALU_LOAD = 3'h0, ALU_SHL = 3'h1, ALU_OR = 3'h2, ALU_XOR = 3'h3,
        ALU_AND = 3'h4, ALU_SHR = 3'h5, ALU_ADD = 3'h6, ALU_ADDC = 3'h7
    } alu_op_e;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_DECODE = 3'b001, S_READ = 3'b011,
        S_WRITE = 3'b010, S_TFETCH = 3'b110, S_SELWAIT = 3'b111
    } state_e;
    typedef struct packed {
        logic ack_oe;
        logic atn_oe;
        logic target_role;
    } scsi_ctl_s;
    typedef struct packed {
        logic [7:0] timing;
        logic [7:0] id;
        logic [7:0] sync;
        logic [7:0] pad;
    } table_entry_s;
endpackage

// ===== rw_decoder_tb.sv
/*
 * Self-checking bench for rw_decoder.
 * Assumes the package, design and memory model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module rw_decoder_tb;
    import rw_decoder_pkg::*;
    logic clk = 0, nrst = 0, awv = 0, wv = 0, bry = 1, arv = 0, rry = 1, ok = 0, fl = 0, c = 0;
    logic [7:0] aw = 0, ar = 0, fb = 0;
    logic [7:0] mr [2];
    logic [31:0] wd = 0, taddr, rdat, ta = 0, st, r;
    logic [3:0] dly = 0, sid;
    logic [1:0] bresp, rresp, rr;
    logic awr, wrdy, bv, arr, rv, treq, tack, ss, satn, jmp, ill;
    table_entry_s tdata;
    scsi_ctl_s so;
    int bad_count = 0, compares = 0, seed = 32'h63fc, starts = 0, jumps = 0, ills = 0, jx = 0;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (ss) starts <= starts + 1;
        if (jmp) jumps <= jumps + 1;
        if (ill) ills <= ills + 1;
        if (treq) ta <= taddr;
    end
    rw_decoder u_dut (.clk_in(clk), .nrst_in(nrst), .ce_in(1'h1), .s_awaddr_in(aw), .s_awvalid_in(awv),
        .s_awready_out(awr), .s_wdata_in(wd), .s_wstrb_in(4'hf), .s_wvalid_in(wv), .s_wready_out(wrdy),
        .s_bresp_out(bresp), .s_bvalid_out(bv), .s_bready_in(bry), .s_araddr_in(ar), .s_arvalid_in(arv),
        .s_arready_out(arr), .s_rdata_out(rdat), .s_rresp_out(rresp), .s_rvalid_out(rv), .s_rready_in(rry),
        .tbl_req_out(treq), .tbl_addr_out(taddr), .tbl_ack_in(tack), .tbl_data_in(tdata), .sel_start_out(ss),
        .sel_id_out(sid), .sel_atn_out(satn), .sel_ok_in(ok), .sel_fail_in(fl), .jump_out(jmp),
        .illegal_out(ill), .scsi_out(so));
    tbl_mem_model u_mem (.clk_in(clk), .req_in(treq), .addr_in(taddr), .dly_in(dly), .ack_out(tack),
        .data_out(tdata));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 60) begin
            bad_count++;
            tally_and_finish;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        aw <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wrdy) wv <= 0;
            if (bv) break;
        end
        tmo(n);
        chk(bresp, {30'h0, a > A_TABLE ? 2'h3 : 2'h0});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        ar <= a;
        arv <= 1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (arr) arv <= 0;
            if (rv) break;
        end
        tmo(n);
        d = rdat;
        rr = rresp;
    endtask
    task automatic idle;
        int n;
        for (n = 0; n < 60; n++) begin
            rd(A_STATUS, st);
            if (st[ST_BUSY] === 1'h0) break;
        end
        tmo(n);
    endtask
    task automatic rw(input logic [2:0] op, input logic [2:0] f, input logic u, input logic i, input logic [7:0] im);
        logic [7:0] s, b, q;
        logic k;
        s = op == OP_FROMFB ? fb : mr[i];
        b = u ? fb : im;
        k = c;
        case (f)
            ALU_LOAD: q = b;
            ALU_SHL: {k, q} = {s, c};
            ALU_OR: q = s | b;
            ALU_XOR: q = s ^ b;
            ALU_AND: q = s & b;
            ALU_SHR: {q, k} = {c, s};
            ALU_ADD: {k, q} = s + b;
            default: {k, q} = s + b + c;
        endcase
        if (op == OP_TOFB) fb = q;
        else mr[i] = q;
        c = k;
        wr(A_WORD0, {2'h1, op, f, u, 6'h10, i, im, 8'h0});
        wr(A_CTRL, 32'h1);
        idle;
        chk(st[15:8], fb);
        chk(st[ST_CARRY], c);
    endtask
    task automatic sc(input logic [2:0] op, input logic [10:0] m, input logic [2:0] e);
        if (m[F_CARRY]) c = op == OP_SET;
        wr(A_WORD0, {2'h1, op, 16'h0, m});
        wr(A_CTRL, 32'h1);
        idle;
        chk(st[ST_CARRY], c);
        chk(st[ST_TARGET], e[0]);
        chk(so, e);
    endtask
    task automatic sel(input logic [2:0] m, input logic [23:0] lo, input logic [31:0] w1, input logic f,
            input logic [31:0] ep, input logic [3:0] id, input logic [31:0] ea, input logic [31:0] te);
        int k, n;
        r = $random(seed);
        dly <= r[3:0];
        wr(A_PTR, 32'h200);
        wr(A_WORD0, {2'h1, OP_SELECT, m, lo});
        wr(A_WORD1, w1);
        k = starts;
        wr(A_CTRL, 32'h1);
        for (n = 0; n < 60 && starts == k; n++) @(posedge clk);
        tmo(n);
        chk(sid, id);
        chk(satn, m[0]);
        fl <= f;
        ok <= !f;
        @(posedge clk);
        fl <= 0;
        ok <= 0;
        jx += f;
        idle;
        rd(A_PTR, st);
        chk(st, ep);
        chk(jumps, jx);
        if (m[1]) begin
            chk(ta, ea);
            rd(A_TABLE, st);
            chk(st, te);
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        rd(8'h40, st);
        chk(rr, 2'h3);
        wr(8'h40, 32'h1);
        wr(A_WORD1, 32'h0);
        wr(A_DSB, 32'h1000);
        rw(OP_RMW, ALU_LOAD, 0, 0, 8'h5a);
        rw(OP_RMW, ALU_LOAD, 0, 1, 8'hc3);
        for (int o = 5; o < 8; o++) begin
            for (int j = 0; j < 8; j++) begin
                r = $random(seed);
                rw(o[2:0], j[2:0], r[5], r[6], r[15:8]);
            end
        end
        sc(OP_SET, 11'h448, 3'b110);
        sc(OP_SET, 11'h200, 3'b001);
        sc(OP_CLEAR, 11'h600, 3'b110);
        sc(OP_CLEAR, 11'h040, 3'b010);
        sc(OP_CLEAR, 11'h008, 3'b000);
        wr(A_WORD0, {2'h1, OP_SET, 3'h1, 24'h0});
        wr(A_CTRL, 32'h1);
        idle;
        chk(ills, 1);
        chk(st[ST_ILLEGAL], 1'h1);
        wr(A_STATUS, 32'h2);
        rd(A_STATUS, st);
        chk(st[ST_ILLEGAL], 1'h0);
        sel(3'b001, 24'h050000, 32'h12345670, 1, 32'h12345670, 4'h5, 0, 0);
        sel(3'b000, 24'h030000, 32'h0, 0, 32'h200, 4'h3, 0, 0);
        sel(3'b100, 24'h090000, 32'h00fffff0, 1, 32'h1f0, 4'h9, 0, 0);
        sel(3'b010, 24'h000020, 32'h4440, 1, 32'h4440, 4'h8, 32'h1020, 32'h1c081000);
        sel(3'b110, 24'hfffffc, 32'h10, 1, 32'h210, 4'hf, 32'hffc, 32'hc00f0f00);
        tally_and_finish;
    end
endmodule
`default_nettype wire

// ===== tbl_mem_model.sv
/*
 * Memory that answers table fetches after a chosen delay.
 * Assumes the request is held until acknowledged.
 */
`timescale 1ns/10ps
`default_nettype none
module tbl_mem_model
    import rw_decoder_pkg::*;
(
    input wire logic clk_in,
    input wire logic req_in,
    input wire logic [31:0] addr_in,
    input wire logic [3:0] dly_in,
    output logic ack_out,
    output rw_decoder_pkg::table_entry_s data_out
);
    logic [31:0] last = 32'h0;
    logic ack_q = 1'h0;
    int n = 0;
    assign ack_out = ack_q;
    // Off the ack cycle data are inverted to catch late samples.
    always @(posedge clk_in) begin
        ack_q <= 1'h0;
        data_out <= ~last;
        if (req_in && !ack_q) begin
            if (n >= dly_in) begin
                last = {addr_in[7:0] ^ 8'h3c, 4'h0, addr_in[5:2], addr_in[15:8], 8'h0};
                ack_q <= 1'h1;
                data_out <= last;
                n = 0;
            end else n++;
        end
    end
endmodule
`default_nettype wire
